// File: core/osq_map.svh
/*
  Register offsets, field positions, reset values and timing figures of
  the optical sample queue and mode control block.
  Assumes an 8-bit register space reached over the two-wire serial link.
*/
`ifndef OSQ_MAP_SVH
`define OSQ_MAP_SVH

// Register offsets
`define OSQ_OFS_STATUS 8'h00
`define OSQ_OFS_WPTR 8'h04
`define OSQ_OFS_LOST 8'h05
`define OSQ_OFS_RPTR 8'h06
`define OSQ_OFS_DATA 8'h07
`define OSQ_OFS_QCFG 8'h08
`define OSQ_OFS_CTL1 8'h09
`define OSQ_OFS_CONV 8'h0A
`define OSQ_OFS_AMP1 8'h0C
`define OSQ_OFS_AMP2 8'h0D
`define OSQ_OFS_AMP3 8'h0E
`define OSQ_OFS_AMP4 8'h0F
`define OSQ_OFS_RANGE 8'h11
`define OSQ_OFS_PILOT 8'h12
`define OSQ_OFS_SEQ1 8'h13
`define OSQ_OFS_SEQ2 8'h14

// Field positions
`define OSQ_BIT_SHUTDOWN 7
`define OSQ_BIT_SWRESET 6
`define OSQ_BIT_AMBDET 2
`define OSQ_BIT_ROLLOVER 4
`define OSQ_BIT_AFULL 7
`define OSQ_BIT_NEWSMP 6
`define OSQ_BIT_PWRRDY 0
`define OSQ_CTL1_WMASK 8'hDF

// Reset values
`define OSQ_RST_QCFG 8'h0F
`define OSQ_RST_ZERO 8'h00

// Queue geometry
`define OSQ_QUEUE_DEPTH 6'h20
`define OSQ_LOST_MAX 5'h1F

// Timing: clock rate and the finest sample-rate step
`define OSQ_CLK_HZ 250000000
`define OSQ_BASE_RATE_HZ 16000

// Serial link address; arbitrary value
`define OSQ_DEV_ADDR 7'h2A

`endif

// File: core/osq_pkg.sv
/*
  Types of the optical sample queue and mode control block.
  Assumes osq_map.svh for numeric constants.
*/
package osq_pkg;

  typedef enum logic [2:0] {
    I_IDLE, I_ADDR, I_REG, I_WDATA, I_RDATA, I_ACK, I_MACK
  } osq_link_state_type;

  typedef enum logic [1:0] {S_WAIT, S_CONV, S_EMIT} osq_smp_state_type;

  // Conversion request to the analog front end
  typedef struct packed {
    logic start;
    logic [3:0] led;
    logic [7:0] amplitude;
    logic [1:0] led_current_ranges;
    logic [1:0] adc_range;
    logic [1:0] pulse_width;
    logic amb_cancel_en;
    logic filter_en;
  } osq_conv_type;

  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic scl_f;
    logic sda_f;
    osq_link_state_type st;
    osq_link_state_type after;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic [7:0] ptr;
    logic sda_low;
  } osq_link_type;

  typedef struct packed {
    logic [7:0] qcfg;
    logic [7:0] ctl1;
    logic [7:0] conv;
    logic [3:0][7:0] amp;
    logic [7:0] rng;
    logic [7:0] pilot;
    logic [1:0][7:0] seq;
  } osq_regs_type;

  typedef struct packed {
    osq_link_type link;
    osq_regs_type regs;
    logic [4:0] wr;
    logic [4:0] rd;
    logic full;
    logic [4:0] lost;
    logic a_full;
    logic new_smp;
    logic power_ready_flag;
    logic [1:0] q_el;
    logic [1:0] q_part;
    logic [1:0] w_el;
    osq_smp_state_type sst;
    logic [1:0] el;
    logic [4:0] avg_cnt;
    logic [23:0] tick;
    logic [3:0][23:0] acc;
    osq_conv_type conv;
  } osq_state_type;

endpackage

// File: core/osq_core.sv
/*
  Optical sample queue, averaging sequencer and mode control, with the
  serial register link and a staging FIFO between averager and queue.
  Assumes SCL/SDA come from pins, the analog front end answers each
  conversion request on this clock, and proximity events are pulses.
*/
`include "osq_map.svh"
`timescale 1ns/100ps
`default_nettype none

module osq_stage_fifo #(
  parameter int unsigned P_WIDTH = 20,
  parameter int unsigned P_DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_flush,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [P_WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [P_WIDTH-1:0] o_out_data
);
  localparam int unsigned AW = $clog2(P_DEPTH);
  logic [P_WIDTH-1:0] mem [0:P_DEPTH-1];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] count;
  logic push;
  logic pop;

  // Handshakes from the fill count
  assign o_in_ready = count != (AW+1)'(P_DEPTH);
  assign o_out_valid = count != '0;
  assign o_out_data = mem[rp];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  // Pointers and count
  always_ff @(posedge i_clk) begin
    if (i_rst || i_flush) begin
      wp <= '0;
      rp <= '0;
      count <= '0;
    end else begin
      if (push) wp <= AW'(wp + 1'b1);
      if (pop) rp <= AW'(rp + 1'b1);
      count <= (AW+1)'(count + push - pop);
    end
  end

  // Storage
  always_ff @(posedge i_clk) begin
    if (push) mem[wp] <= i_in_data;
  end
endmodule

module osq_core import osq_pkg::*; #(
  parameter int unsigned P_BASE_CYCLES = `OSQ_CLK_HZ / `OSQ_BASE_RATE_HZ,
  parameter logic [6:0] P_DEV_ADDR = `OSQ_DEV_ADDR
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe_n,
  input wire logic i_conv_done,
  input wire logic [18:0] i_conv_data,
  input wire logic i_prox_mode,
  input wire logic i_proximity_detected_interrupt,
  output osq_conv_type o_conv,
  output logic o_osc_enable
);
  // Element code for slot i, 0 when off or reserved
  function automatic logic [3:0] led_of(input logic [1:0] mode,
      input logic [1:0][7:0] seq, input logic [1:0] i);
    logic [3:0] c;
    c = 4'h0;
    unique case (mode)
      2'b00: c = 4'h0;
      2'b01: c = (i == 2'h0) ? 4'h1 : 4'h0;
      2'b10: c = (i == 2'h0) ? 4'h1 : ((i == 2'h1) ? 4'h2 : 4'h0);
      2'b11: c = i[0] ? seq[i[1]][7:4] : seq[i[1]][3:0];
    endcase
    if (c > 4'h8) c = 4'h0;
    return c;
  endfunction

  // Number of leading active slots
  function automatic logic [2:0] elem_count(input logic [1:0] mode,
      input logic [1:0][7:0] seq);
    logic [2:0] n;
    logic stop;
    n = 3'h0;
    stop = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (!stop && led_of(mode, seq, 2'(i)) != 4'h0) n = 3'(n + 3'h1);
      else stop = 1'b1;
    end
    return n;
  endfunction

  // Conversion request for one element
  function automatic osq_conv_type conv_for(input osq_regs_type g,
      input logic [1:0] i);
    osq_conv_type c;
    logic [1:0] idx;
    c.led = led_of(g.ctl1[1:0], g.seq, i);
    idx = 2'(c.led - 4'h1);
    c.start = 1'b1;
    c.amplitude = (c.led > 4'h4) ? g.pilot : g.amp[idx];
    c.led_current_ranges = g.rng[idx*2 +: 2];
    c.adc_range = g.conv[6:5];
    c.pulse_width = g.conv[1:0];
    c.amb_cancel_en = !g.ctl1[`OSQ_BIT_AMBDET];
    c.filter_en = !g.ctl1[`OSQ_BIT_AMBDET];
    return c;
  endfunction

  // Tick multiple of the base step per rate code
  function automatic logic [8:0] rate_mult(input logic [2:0] sr);
    logic [8:0] m;
    unique case (sr)
      3'h0: m = 9'h140; // 50 sps
      3'h1: m = 9'h0A0; // 100
      3'h2: m = 9'h050; // 200
      3'h3: m = 9'h028; // 400
      3'h4: m = 9'h014; // 800
      3'h5: m = 9'h010; // 1000
      3'h6: m = 9'h00A; // 1600
      3'h7: m = 9'h005; // 3200
    endcase
    return m;
  endfunction

  function automatic osq_state_type reset_state();
    osq_state_type s;
    s = '0;
    s.regs.qcfg = `OSQ_RST_QCFG;
    s.power_ready_flag = 1'b1;
    s.link.scl_s = 3'h7;
    s.link.sda_s = 3'h7;
    s.link.scl_f = 1'b1;
    s.link.sda_f = 1'b1;
    s.link.st = I_IDLE;
    s.link.after = I_IDLE;
    s.sst = S_WAIT;
    s.conv.amb_cancel_en = 1'b1;
    s.conv.filter_en = 1'b1;
    return s;
  endfunction

  localparam osq_state_type RST_STATE = reset_state();

  osq_state_type r;
  osq_state_type next_r;
  osq_link_type keep_link;
  logic keep_pwr;
  logic [18:0] mem [0:31][0:3];
  logic scl_new, sda_new, scl_rise, scl_fall, start_c, stop_c;
  logic [2:0] n_el;
  logic [2:0] avg_sh;
  logic active, ro_eff, empty, fire;
  logic [23:0] period;
  logic [23:0] shifted;
  logic st_in_valid, st_in_ready, st_out_valid, st_out_ready;
  logic [19:0] st_in_data, st_out_data;
  logic take, mem_we;
  logic [18:0] el_word;
  logic [7:0] rd_byte;
  logic [5:0] fill;

  // Filtered pins: a change counts when second and third stages agree
  assign scl_new = (r.link.scl_s[1] == r.link.scl_s[2]) ?
      r.link.scl_s[2] : r.link.scl_f;
  assign sda_new = (r.link.sda_s[1] == r.link.sda_s[2]) ?
      r.link.sda_s[2] : r.link.sda_f;
  assign scl_rise = scl_new && !r.link.scl_f;
  assign scl_fall = !scl_new && r.link.scl_f;
  assign start_c = r.link.scl_f && scl_new && r.link.sda_f && !sda_new;
  assign stop_c = r.link.scl_f && scl_new && !r.link.sda_f && sda_new;

  // Derived configuration
  assign n_el = elem_count(r.regs.ctl1[1:0], r.regs.seq);
  assign avg_sh = (r.regs.qcfg[7:5] > 3'h5) ? 3'h5 : r.regs.qcfg[7:5];
  assign active = !r.regs.ctl1[`OSQ_BIT_SHUTDOWN] && n_el != 3'h0;
  assign period = 24'(P_BASE_CYCLES * rate_mult(r.regs.conv[4:2]));
  assign fire = active && r.tick >= 24'(period - 24'h1);
  assign ro_eff = r.regs.qcfg[`OSQ_BIT_ROLLOVER] || i_prox_mode;
  assign empty = (r.wr == r.rd) && !r.full;

  // Staging path: per-element averages, result = sum >> log2(count)
  assign shifted = r.acc[r.el] >> avg_sh;
  assign st_in_valid = r.sst == S_EMIT;
  assign st_in_data = {({1'b0, r.el} == 3'(n_el - 3'h1)), shifted[18:0]};
  assign st_out_ready = r.link.st != I_RDATA;
  assign take = st_out_valid && st_out_ready;
  assign mem_we = take && !(r.full && !ro_eff);

  // Fill level and data byte under the read pointer
  assign fill = r.full ? `OSQ_QUEUE_DEPTH : {1'b0, 5'(r.wr - r.rd)};
  assign el_word = mem[r.rd][r.q_el];

  osq_stage_fifo #(.P_WIDTH(20), .P_DEPTH(16)) u_stage (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_flush(r.regs.ctl1[`OSQ_BIT_SWRESET]),
    .i_in_valid(st_in_valid),
    .o_in_ready(st_in_ready),
    .i_in_data(st_in_data),
    .o_out_valid(st_out_valid),
    .i_out_ready(st_out_ready),
    .o_out_data(st_out_data)
  );

  // Register read decode
  always_comb begin
    rd_byte = 8'h00;
    unique case (r.link.ptr)
      `OSQ_OFS_STATUS: rd_byte = {r.a_full, r.new_smp, 5'h00, r.power_ready_flag};
      `OSQ_OFS_WPTR: rd_byte = {3'h0, r.wr};
      `OSQ_OFS_LOST: rd_byte = {3'h0, r.lost};
      `OSQ_OFS_RPTR: rd_byte = {3'h0, r.rd};
      `OSQ_OFS_DATA: begin
        if (empty) rd_byte = 8'h00;
        else if (r.q_part == 2'h0) rd_byte = {5'h00, el_word[18:16]};
        else if (r.q_part == 2'h1) rd_byte = el_word[15:8];
        else rd_byte = el_word[7:0];
      end
      `OSQ_OFS_QCFG: rd_byte = r.regs.qcfg;
      `OSQ_OFS_CTL1: rd_byte = r.regs.ctl1;
      `OSQ_OFS_CONV: rd_byte = r.regs.conv;
      `OSQ_OFS_AMP1: rd_byte = r.regs.amp[0];
      `OSQ_OFS_AMP2: rd_byte = r.regs.amp[1];
      `OSQ_OFS_AMP3: rd_byte = r.regs.amp[2];
      `OSQ_OFS_AMP4: rd_byte = r.regs.amp[3];
      `OSQ_OFS_RANGE: rd_byte = r.regs.rng;
      `OSQ_OFS_PILOT: rd_byte = r.regs.pilot;
      `OSQ_OFS_SEQ1: rd_byte = r.regs.seq[0];
      `OSQ_OFS_SEQ2: rd_byte = r.regs.seq[1];
      default: rd_byte = 8'h00;
    endcase
  end

  // Next state: link, registers, queue and sequencer
  always_comb begin
    next_r = r;
    next_r.conv.start = 1'b0;
    next_r.link.scl_s = {r.link.scl_s[1:0], i_scl};
    next_r.link.sda_s = {r.link.sda_s[1:0], i_sda};
    next_r.link.scl_f = scl_new;
    next_r.link.sda_f = sda_new;

    // Serial link: bits in on rising SCL, driven on falling SCL
    if (start_c) begin
      next_r.link.st = I_ADDR;
      next_r.link.cnt = 4'h0;
      next_r.link.sda_low = 1'b0;
    end else if (stop_c) begin
      next_r.link.st = I_IDLE;
      next_r.link.sda_low = 1'b0;
    end else if (scl_rise) begin
      if (r.link.st == I_MACK && r.link.sda_f) next_r.link.after = I_IDLE;
      else if (r.link.st == I_MACK) next_r.link.after = I_RDATA;
      else if (r.link.st != I_IDLE && r.link.st != I_ACK) begin
        next_r.link.sh = {r.link.sh[6:0], r.link.sda_f};
        next_r.link.cnt = 4'(r.link.cnt + 4'h1);
      end
    end else if (scl_fall) begin
      unique case (r.link.st)
        I_IDLE: next_r.link.sda_low = 1'b0;
        I_ADDR: if (r.link.cnt == 4'h8) begin
          if (r.link.sh[7:1] == P_DEV_ADDR) begin
            next_r.link.st = I_ACK;
            next_r.link.sda_low = 1'b1;
            next_r.link.after = r.link.sh[0] ? I_RDATA : I_REG;
          end else next_r.link.st = I_IDLE;
        end
        I_REG: if (r.link.cnt == 4'h8) begin
          next_r.link.ptr = r.link.sh;
          next_r.link.st = I_ACK;
          next_r.link.sda_low = 1'b1;
          next_r.link.after = I_WDATA;
        end
        I_WDATA: if (r.link.cnt == 4'h8) begin
          next_r.link.st = I_ACK;
          next_r.link.sda_low = 1'b1;
          next_r.link.after = I_WDATA;
          if (r.link.ptr != `OSQ_OFS_DATA)
            next_r.link.ptr = 8'(r.link.ptr + 8'h01);
          unique case (r.link.ptr)
            `OSQ_OFS_RPTR: begin
              next_r.rd = r.link.sh[4:0];
              next_r.full = 1'b0;
              next_r.q_el = 2'h0;
              next_r.q_part = 2'h0;
            end
            `OSQ_OFS_QCFG: next_r.regs.qcfg = r.link.sh;
            `OSQ_OFS_CTL1:
              next_r.regs.ctl1 = r.link.sh & `OSQ_CTL1_WMASK;
            `OSQ_OFS_CONV: next_r.regs.conv = r.link.sh;
            `OSQ_OFS_AMP1: next_r.regs.amp[0] = r.link.sh;
            `OSQ_OFS_AMP2: next_r.regs.amp[1] = r.link.sh;
            `OSQ_OFS_AMP3: next_r.regs.amp[2] = r.link.sh;
            `OSQ_OFS_AMP4: next_r.regs.amp[3] = r.link.sh;
            `OSQ_OFS_RANGE: next_r.regs.rng = r.link.sh;
            `OSQ_OFS_PILOT: next_r.regs.pilot = r.link.sh;
            `OSQ_OFS_SEQ1: next_r.regs.seq[0] = r.link.sh;
            `OSQ_OFS_SEQ2: next_r.regs.seq[1] = r.link.sh;
            default: next_r.regs = r.regs;
          endcase
        end
        I_RDATA: begin
          if (r.link.cnt == 4'h8) begin
            next_r.link.st = I_MACK;
            next_r.link.sda_low = 1'b0;
          end else begin
            next_r.link.tx = {r.link.tx[6:0], 1'b0};
            next_r.link.sda_low = !r.link.tx[6];
          end
        end
        I_ACK, I_MACK: begin
          next_r.link.cnt = 4'h0;
          next_r.link.sda_low = 1'b0;
          next_r.link.st = r.link.after;
          if (r.link.after == I_RDATA) begin
            // Load a byte and apply the read's side effects
            next_r.link.tx = rd_byte;
            next_r.link.sda_low = !rd_byte[7];
            if (r.link.ptr != `OSQ_OFS_DATA)
              next_r.link.ptr = 8'(r.link.ptr + 8'h01);
            if (r.link.ptr == `OSQ_OFS_STATUS) begin
              next_r.a_full = 1'b0;
              next_r.new_smp = 1'b0;
              next_r.power_ready_flag = 1'b0;
            end
            if (r.link.ptr == `OSQ_OFS_DATA && !empty) begin
              next_r.q_part = 2'(r.q_part + 2'h1);
              if (r.q_part == 2'h2) begin
                next_r.q_part = 2'h0;
                next_r.q_el = 2'(r.q_el + 2'h1);
                if ({1'b0, r.q_el} >= 3'(n_el - 3'h1)) begin
                  next_r.q_el = 2'h0;
                  next_r.rd = 5'(r.rd + 5'h01);
                  next_r.full = 1'b0;
                  next_r.lost = 5'h00;
                  next_r.new_smp = 1'b0;
                end
              end
            end
          end
        end
        default: next_r.link.st = I_IDLE;
      endcase
    end

    // Queue fill from the staging FIFO; events win over host clears
    if (take) begin
      next_r.w_el = 2'(r.w_el + 2'h1);
      if (st_out_data[19]) begin
        next_r.w_el = 2'h0;
        if (!r.full) begin
          next_r.wr = 5'(r.wr + 5'h01);
          next_r.full = 5'(r.wr + 5'h01) == next_r.rd;
          next_r.new_smp = 1'b1;
          if (6'(fill + 6'h01) >= 6'(`OSQ_QUEUE_DEPTH - r.regs.qcfg[3:0]))
            next_r.a_full = 1'b1;
        end else begin
          if (ro_eff) begin
            next_r.wr = 5'(r.wr + 5'h01);
            next_r.rd = 5'(r.rd + 5'h01);
            next_r.q_el = 2'h0;
            next_r.q_part = 2'h0;
            next_r.new_smp = 1'b1;
          end
          if (r.lost != `OSQ_LOST_MAX)
            next_r.lost = 5'(r.lost + 5'h01);
        end
      end
    end

    // Proximity detection empties the queue
    if (i_proximity_detected_interrupt) begin
      next_r.rd = next_r.wr;
      next_r.full = 1'b0;
      next_r.q_el = 2'h0;
      next_r.q_part = 2'h0;
    end

    // Sample timer and averaging sequencer
    next_r.tick = (!active || fire) ? 24'h0 : 24'(r.tick + 24'h1);
    next_r.conv.amb_cancel_en = !r.regs.ctl1[`OSQ_BIT_AMBDET];
    next_r.conv.filter_en = !r.regs.ctl1[`OSQ_BIT_AMBDET];
    // Range and width follow their register even while idle
    next_r.conv.adc_range = r.regs.conv[6:5];
    next_r.conv.pulse_width = r.regs.conv[1:0];
    unique case (r.sst)
      S_WAIT: if (fire) begin
        next_r.el = 2'h0;
        next_r.conv = conv_for(r.regs, 2'h0);
        next_r.sst = S_CONV;
      end
      S_CONV: if (i_conv_done) begin
        next_r.acc[r.el] = (r.avg_cnt == 5'h00) ? 24'(i_conv_data) :
            24'(r.acc[r.el] + 24'(i_conv_data));
        if ({1'b0, r.el} >= 3'(n_el - 3'h1)) begin
          next_r.el = 2'h0;
          if (r.avg_cnt == 5'((6'h01 << avg_sh) - 6'h01)) begin
            next_r.avg_cnt = 5'h00;
            next_r.sst = S_EMIT;
          end else begin
            next_r.avg_cnt = 5'(r.avg_cnt + 5'h01);
            next_r.sst = S_WAIT;
          end
        end else begin
          next_r.el = 2'(r.el + 2'h1);
          next_r.conv = conv_for(r.regs, 2'(r.el + 2'h1));
        end
      end
      S_EMIT: if (st_in_ready) begin
        next_r.el = 2'(r.el + 2'h1);
        if (st_in_data[19]) begin
          next_r.el = 2'h0;
          next_r.sst = S_WAIT;
        end
      end
    endcase
    // A finished average still drains into staging after a stop
    if (!active) begin
      if (r.sst != S_EMIT) next_r.sst = S_WAIT;
      next_r.avg_cnt = 5'h00;
      next_r.conv.start = 1'b0;
    end

    // Shutdown holds all flags clear
    if (r.regs.ctl1[`OSQ_BIT_SHUTDOWN]) begin
      next_r.a_full = 1'b0;
      next_r.new_smp = 1'b0;
      next_r.power_ready_flag = 1'b0;
    end

    // Software reset: all but the link and power-ready return to reset
    keep_link = next_r.link;
    keep_pwr = next_r.power_ready_flag;
    if (r.regs.ctl1[`OSQ_BIT_SWRESET]) begin
      next_r = RST_STATE;
      next_r.link = keep_link;
      next_r.power_ready_flag = keep_pwr;
    end
  end

  // State register
  always_ff @(posedge i_clk) begin
    if (i_rst) r <= RST_STATE;
    else r <= next_r;
  end

  // Queue storage
  always_ff @(posedge i_clk) begin
    if (mem_we) mem[r.wr][r.w_el] <= st_out_data[18:0];
  end

  // Outputs
  assign o_sda_out = 1'b0;
  assign o_sda_oe_n = !r.link.sda_low;
  assign o_conv = r.conv;
  assign o_osc_enable = !r.regs.ctl1[`OSQ_BIT_SHUTDOWN];
endmodule

`default_nettype wire

// File: testbench/osq_core_props.sv
/*
  Port assertions of osq_core, bound into every instance.
  Assumes host SCL phases of at least eight clocks.
*/
`timescale 1ns/100ps
`default_nettype none
module osq_core_props import osq_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic o_sda_out,
  input wire logic o_sda_oe_n,
  input wire osq_conv_type o_conv,
  input wire logic o_osc_enable
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Pin is open drain, data only pulls low
  property p_sda_od; o_sda_out == 1'b0; endproperty
  // SDA moves only while SCL is low
  property p_ack_low; !$stable(o_sda_oe_n) |-> !i_scl; endproperty
  // Values right after reset
  property p_rst_val;
    $past(i_rst) |-> o_osc_enable && o_conv.amb_cancel_en &&
      o_conv.filter_en && o_sda_oe_n && !o_conv.start;
  endproperty
  // Cancellation and filter go off together
  property p_amb; o_conv.amb_cancel_en == o_conv.filter_en; endproperty
  // No conversion while the oscillator is stopped
  property p_shut; !o_osc_enable |-> !o_conv.start; endproperty
  // Only valid sequence codes are fired
  property p_led; o_conv.start |-> o_conv.led inside {[4'h1:4'h8]};
  endproperty
  // Start is a single-cycle pulse
  property p_pulse; o_conv.start |=> !o_conv.start; endproperty
  // Register side effects land at the ACK fall
  property p_osc_low; !$stable(o_osc_enable) |-> !i_scl; endproperty
  property p_conv_low;
    !$stable({o_conv.adc_range, o_conv.pulse_width}) |-> !i_scl;
  endproperty
  a_sda_od: assert property (p_sda_od)
    else $error("sda output not low");
  a_ack_low: assert property (p_ack_low)
    else $error("sda enable moved with scl high");
  a_rst_val: assert property (p_rst_val)
    else $error("bad value after reset");
  a_amb: assert property (p_amb)
    else $error("cancel and filter differ");
  a_shut: assert property (p_shut)
    else $error("conversion in shutdown");
  a_led: assert property (p_led)
    else $error("bad sequence code");
  a_pulse: assert property (p_pulse)
    else $error("start longer than one cycle");
  a_osc_low: assert property (p_osc_low)
    else $error("oscillator enable moved with scl high");
  a_conv_low: assert property (p_conv_low)
    else $error("range moved with scl high");
  c_start: cover property (o_conv.start);
  c_ack: cover property ($fell(o_sda_oe_n));
  c_shut: cover property ($fell(o_osc_enable));
endmodule
bind osq_core osq_core_props u_props (
  .i_clk(i_clk),
  .i_rst(i_rst),
  .i_scl(i_scl),
  .o_sda_out(o_sda_out),
  .o_sda_oe_n(o_sda_oe_n),
  .o_conv(o_conv),
  .o_osc_enable(o_osc_enable)
);
`default_nettype wire

// File: testbench/osq_host_model.sv
/*
  Host model: two-wire master with register write and read tasks.
  Assumes the bench resolves SDA with a pull-up.
*/
`timescale 1ns/100ps
`default_nettype none
module osq_host_model #(
  parameter logic [6:0] P_ADDR = 7'h2A
) (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low,
  output logic o_rd_valid,
  output logic [7:0] o_rd_data
);
  logic s;
  // Idle bus
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
    o_rd_valid = 1'b0;
    o_rd_data = 8'h00;
  end
  task automatic w(input int k);
    repeat (k) @(posedge i_clk);
  endtask
  // One bit, SCL low and high nine clocks each
  task automatic bit_io(input logic b);
    w(4);
    o_sda_low <= !b;
    w(5);
    o_scl <= 1'b1;
    w(9);
    s = i_sda;
    o_scl <= 1'b0;
  endtask
  // Start, also used as repeated start
  task automatic start();
    w(9);
    o_sda_low <= 1'b0;
    w(9);
    o_scl <= 1'b1;
    w(9);
    o_sda_low <= 1'b1;
    w(9);
    o_scl <= 1'b0;
  endtask
  task automatic stop();
    w(9);
    o_sda_low <= 1'b1;
    w(9);
    o_scl <= 1'b1;
    w(9);
    o_sda_low <= 1'b0;
    w(9);
  endtask
  // Byte out, then release for the ACK
  task automatic put(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) bit_io(b[i]);
    bit_io(1'b1);
  endtask
  task automatic wr(input logic [7:0] r, input logic [7:0] v);
    start();
    put({P_ADDR, 1'b0});
    put(r);
    put(v);
    stop();
  endtask
  // Read n bytes, NACK on the last
  task automatic rd(input logic [7:0] r, input int n);
    logic [7:0] b;
    start();
    put({P_ADDR, 1'b0});
    put(r);
    start();
    put({P_ADDR, 1'b1});
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) begin
        bit_io(1'b1);
        b[i] = s;
      end
      o_rd_data <= b;
      o_rd_valid <= 1'b1;
      w(1);
      o_rd_valid <= 1'b0;
      bit_io(k == n - 1);
    end
    stop();
  endtask
endmodule
`default_nettype wire

// File: testbench/testbench.sv
/*
  Testbench of osq_core: host model on the link, front end in the bench.
  Assumes a short base period so queue fill takes few clocks.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam logic [6:0] ADDR = 7'h2A; // Arbitrary link address
  logic clk = 1'b0, rst = 1'b1, done = 1'b0, proximity_detected_interrupt = 1'b0;
  logic prox_mode = 1'b0, scl, host_low, oe_n, osc, rdv, sda;
  logic [18:0] cdata = 19'h00000;
  logic [18:0] fe [256];
  logic [7:0] rdd, n = 8'h00, exp_q [$];
  logic [1:0] pend = 2'b00;
  osq_pkg::osq_conv_type conv;
  int bad_count = 0, total_checks = 0;
  assign sda = !(host_low || !oe_n);
  always #2 clk = ~clk;
  osq_core #(.P_BASE_CYCLES(2), .P_DEV_ADDR(ADDR)) u_dut (.i_clk(clk),
    .i_rst(rst), .i_scl(scl), .i_sda(sda), .o_sda_out(), .o_sda_oe_n(oe_n),
    .i_conv_done(done), .i_conv_data(cdata), .i_prox_mode(prox_mode),
    .i_proximity_detected_interrupt(proximity_detected_interrupt), .o_conv(conv), .o_osc_enable(osc));
  osq_host_model #(.P_ADDR(ADDR)) u_host (.i_clk(clk), .i_sda(sda),
    .o_scl(scl), .o_sda_low(host_low), .o_rd_valid(rdv), .o_rd_data(rdd));
  // Front end answers each start three cycles later
  always @(posedge clk) begin
    pend <= {pend[0], conv.start === 1'b1};
    done <= pend[1];
    if (pend[1]) cdata <= fe[n];
    // Count only results that meet a running sampler
    if (done && osc) n <= n + 8'd1;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Each byte read meets the oldest note
  always @(posedge clk) if (rdv) chk(rdd, exp_q.size() ? exp_q.pop_front()
    : 8'hXX);
  task automatic rx(input logic [7:0] r, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.rd(r, 1);
  endtask
  // Note the three bytes of one sample
  task automatic smp(input logic [7:0] i);
    exp_q.push_back({5'h00, fe[i][18:16]});
    exp_q.push_back(fe[i][15:8]);
    exp_q.push_back(fe[i][7:0]);
  endtask
  // Reset values of the configuration registers from QCFG to RANGE
  task automatic regtab();
    logic [7:0] ofs [8] = '{8'h08, 8'h09, 8'h0A, 8'h0C, 8'h0D, 8'h0E,
      8'h0F, 8'h11};
    for (int i = 0; i < 8; i++) rx(ofs[i], i == 0 ? 8'h0F : 8'h00);
  endtask
  // Fill past full, then read, reread and flush
  task automatic run(input logic roll);
    logic [7:0] n0, m, o;
    n0 = n;
    u_host.wr(8'h08, {3'b000, roll, 4'hF});
    u_host.wr(8'h0A, 8'h1C);
    u_host.wr(8'h09, 8'h01);
    repeat (400) @(posedge clk);
    rx(8'h00, {2'b11, 5'h00, !roll});
    u_host.wr(8'h09, 8'h81);
    chk({7'h00, osc}, 8'h00);
    rx(8'h00, 8'h00);
    m = n - n0;
    o = n0 + (roll ? m - 8'd32 : 8'd0);
    rx(8'h04, {3'b000, roll ? m[4:0] : 5'h00});
    rx(8'h06, {3'b000, roll ? m[4:0] : 5'h00});
    rx(8'h05, m > 8'd62 ? 8'h1F : m - 8'd32);
    smp(o);
    smp(o + 8'd1);
    u_host.rd(8'h07, 6);
    rx(8'h06, {3'b000, (roll ? m[4:0] : 5'h00) + 5'd2});
    rx(8'h05, 8'h00);
    u_host.wr(8'h06, {3'b000, (roll ? m[4:0] : 5'h00) + 5'd1});
    smp(o + 8'd1);
    u_host.rd(8'h07, 3);
    @(posedge clk) proximity_detected_interrupt <= 1'b1;
    @(posedge clk) proximity_detected_interrupt <= 1'b0;
    rx(8'h07, 8'h00);
  endtask
  // Main sequence
  initial begin
    logic [7:0] v;
    v = 8'($urandom(32'hE24D2366));
    for (int i = 0; i < 256; i++) fe[i] = 19'($urandom);
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    regtab();
    u_host.wr(8'h0A, v);
    chk({conv.adc_range, conv.pulse_width}, {4'h0, v[6:5], v[1:0]});
    rx(8'h0A, v);
    u_host.wr(8'h11, ~v);
    rx(8'h11, ~v);
    u_host.wr(8'h07, v);
    rx(8'h07, 8'h00);
    run(1'b0);
    u_host.wr(8'h09, 8'h40);
    regtab();
    run(1'b1);
    for (int i = 0; i < 100 && exp_q.size() > 0; i++) @(posedge clk);
    if (exp_q.size() > 0) bad_count++;
    test_done();
  end
  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    test_done();
  end
endmodule
`default_nettype wire
